/* hw/scps_slow_clock_pll.v */
// Purpose: Slow clock source selection, main clock measurement and PLL lock tracking
// Assumes: Oscillator and main clock levels arrive synchronous to clk
// Notes:   backup_supply low acts as a loss of the backup domain
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/10ps
`include "scps_defines.vh"

module scps_slow_clock_pll (
  input  wire        clk,
  input  wire        rst,
  input  wire        backup_supply,
  input  wire        rc_osc_level,
  input  wire        slow_xtal_input,
  input  wire        main_clock_signal,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  output reg         slow_clock,
  output reg         slow_clock_valid,
  output reg         rc_osc_enable,
  output reg         xtal_osc_enable,
  output reg         xtal_bypass_enable,
  output reg         slow_source_indicator,
  output reg  [1:0]  pll_enable,
  output reg  [13:0] pll_divider_out,
  output reg  [15:0] pll_multiplier_out,
  output reg  [1:0]  pll_locked_flag,
  output reg         pll_lock_irq
);

  localparam [2:0] ST_RC     = 3'h0;
  localparam [2:0] ST_XSTART = 3'h1;
  localparam [2:0] ST_SWAP   = 3'h2;
  localparam [2:0] ST_RCOFF  = 3'h3;
  localparam [2:0] ST_XTAL   = 3'h4;

  localparam [10:0] VALID_CYCLES = `SCPS_SLOW_VALID_CYCLES;

  wire        dom_rst;
  wire        slow_rise;
  wire        wr_ctrl;
  wire        wr_mode;
  wire        wr_irq;
  wire        wr_freq;
  wire [1:0]  wr_pll;

  reg  [2:0]  sw_state;
  reg  [3:0]  start_cnt;
  reg         slow_xtal_select;
  reg         sel_xtal;
  reg         slow_prev;
  reg  [10:0] valid_cnt;
  reg         main_prev;
  reg  [15:0] main_freq_count;
  reg  [15:0] meas_cnt;
  reg  [4:0]  meas_edges;
  reg         meas_run;
  reg         main_freq_valid;
  reg  [1:0]  clock_irq_enable;
  reg  [6:0]  pll_divider_field [0:1];
  reg  [7:0]  pll_multiplier_field [0:1];
  reg  [5:0]  pll_lock_delay_field [0:1];
  reg  [5:0]  lock_cnt [0:1];
  reg  [1:0]  lock_wait;
  reg  [31:0] next_rdata;
  reg         next_slow;

  assign dom_rst   = rst | ~backup_supply;
  assign slow_rise = slow_clock & ~slow_prev;
  assign wr_ctrl   = reg_write && (reg_addr == `SCPS_SUPPLY_CONTROL_REG);
  assign wr_mode   = reg_write && (reg_addr == `SCPS_SUPPLY_MODE_REG);
  assign wr_irq    = reg_write && (reg_addr == `SCPS_CLOCK_IRQ_ENABLE_REG);
  assign wr_freq   = reg_write && (reg_addr == `SCPS_MAIN_FREQ_MEASURE);
  assign wr_pll[0] = reg_write && (reg_addr == `SCPS_PLL_CONFIG_REG_A);
  assign wr_pll[1] = reg_write && (reg_addr == `SCPS_PLL_CONFIG_REG_B);

  ////////////////////////////////////////////////////////////////////////////
  // Slow clock source switch

  always @* begin
    if (sel_xtal) begin
      next_slow = slow_xtal_input;
    end else begin
      next_slow = rc_osc_level;
    end
  end

  always @(posedge clk) begin
    if (dom_rst) begin
      sw_state              <= ST_RC;
      start_cnt             <= 4'h0;
      slow_xtal_select      <= 1'b0;
      sel_xtal              <= 1'b0;
      rc_osc_enable         <= 1'b1;
      xtal_osc_enable       <= 1'b0;
      xtal_bypass_enable    <= 1'b0;
      slow_source_indicator <= 1'b0;
      slow_clock            <= 1'b0;
      slow_prev             <= 1'b0;
    end else begin
      slow_prev  <= slow_clock;
      slow_clock <= next_slow;
      if (wr_mode && !slow_xtal_select) begin
        xtal_bypass_enable <= reg_wdata[`SCPS_BYPASS_BIT];
      end
      if (wr_ctrl && reg_wdata[`SCPS_XTAL_SELECT_BIT]) begin
        slow_xtal_select <= 1'b1;
      end
      case (sw_state)
        ST_RC: begin
          if (slow_xtal_select) begin
            xtal_osc_enable <= ~xtal_bypass_enable;
            start_cnt       <= 4'h0;
            sw_state        <= ST_XSTART;
          end
        end
        ST_XSTART: begin
          if (slow_xtal_input && !xtal_prev_high(start_cnt)) begin
            start_cnt <= start_cnt + 4'h1;
          end
          if (start_cnt == `SCPS_XTAL_START_EDGES) begin
            sw_state <= ST_SWAP;
          end
        end
        ST_SWAP: begin
          if (!slow_clock && !rc_osc_level && !slow_xtal_input) begin
            sel_xtal              <= 1'b1;
            slow_source_indicator <= 1'b1;
            sw_state              <= ST_RCOFF;
          end
        end
        ST_RCOFF: begin
          rc_osc_enable <= 1'b0;
          sw_state      <= ST_XTAL;
        end
        ST_XTAL: begin
          sw_state <= ST_XTAL;
        end
        default: begin
          sw_state <= ST_RC;
        end
      endcase
    end
  end

  // Crystal startup edge counter uses the sampled crystal level
  reg xtal_prev;
  always @(posedge clk) begin
    if (dom_rst) begin
      xtal_prev <= 1'b0;
    end else begin
      xtal_prev <= slow_xtal_input;
    end
  end

  function xtal_prev_high;
    input [3:0] unused_cnt;
    begin
      xtal_prev_high = xtal_prev | (unused_cnt == 4'hf);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Slow clock valid delay after backup power-up

  always @(posedge clk) begin
    if (dom_rst) begin
      valid_cnt        <= 11'h000;
      slow_clock_valid <= 1'b0;
    end else if (valid_cnt != VALID_CYCLES) begin
      valid_cnt <= valid_cnt + 11'h001;
    end else begin
      slow_clock_valid <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main clock frequency measurement

  always @(posedge clk) begin
    if (dom_rst) begin
      main_prev       <= 1'b0;
      main_freq_count <= 16'h0000;
      meas_cnt        <= 16'h0000;
      meas_edges      <= 5'h00;
      meas_run        <= 1'b0;
      main_freq_valid <= 1'b0;
    end else begin
      main_prev <= main_clock_signal;
      if (wr_freq && reg_wdata[`SCPS_FREQ_RESTART_BIT]) begin
        main_freq_valid <= 1'b0;
        meas_run        <= 1'b0;
        meas_edges      <= 5'h00;
      end else if (!meas_run && !main_freq_valid && slow_clock_valid && slow_rise) begin
        meas_run   <= 1'b1;
        meas_edges <= 5'h00;
        meas_cnt   <= 16'h0000;
      end else if (meas_run) begin
        if (main_clock_signal && !main_prev && meas_cnt != 16'hffff) begin
          meas_cnt <= meas_cnt + 16'h0001;
        end
        if (slow_rise) begin
          meas_edges <= meas_edges + 5'h01;
          if (meas_edges == `SCPS_MEASURE_SLOW_EDGES - 5'h01) begin
            main_freq_count <= meas_cnt;
            main_freq_valid <= 1'b1;
            meas_run        <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL configuration and lock delay, one per PLL

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pll
      always @(posedge clk) begin
        if (rst) begin
          pll_divider_field[gi]    <= `SCPS_DIV_RESET;
          pll_multiplier_field[gi] <= `SCPS_MUL_RESET;
          pll_lock_delay_field[gi] <= `SCPS_COUNT_RESET;
          lock_cnt[gi]             <= 6'h00;
          lock_wait[gi]            <= 1'b0;
          pll_locked_flag[gi]      <= 1'b0;
          pll_enable[gi]           <= 1'b0;
        end else if (wr_pll[gi]) begin
          pll_divider_field[gi]    <= reg_wdata[`SCPS_DIV_MSB:`SCPS_DIV_LSB];
          pll_multiplier_field[gi] <= reg_wdata[`SCPS_MUL_MSB:`SCPS_MUL_LSB];
          pll_lock_delay_field[gi] <= reg_wdata[`SCPS_COUNT_MSB:`SCPS_COUNT_LSB];
          lock_cnt[gi]             <= reg_wdata[`SCPS_COUNT_MSB:`SCPS_COUNT_LSB];
          pll_enable[gi]           <= (reg_wdata[`SCPS_DIV_MSB:`SCPS_DIV_LSB] != 7'h00) &&
                                      (reg_wdata[`SCPS_MUL_MSB:`SCPS_MUL_LSB] != 8'h00);
          lock_wait[gi]            <= 1'b1;
          if ((reg_wdata[`SCPS_DIV_MSB:`SCPS_DIV_LSB] != pll_divider_field[gi]) ||
              (reg_wdata[`SCPS_MUL_MSB:`SCPS_MUL_LSB] != pll_multiplier_field[gi])) begin
            pll_locked_flag[gi] <= 1'b0;
          end
        end else if (lock_wait[gi]) begin
          if (!pll_enable[gi]) begin
            lock_wait[gi]       <= 1'b0;
            pll_locked_flag[gi] <= 1'b0;
          end else if (lock_cnt[gi] == 6'h00) begin
            lock_wait[gi]       <= 1'b0;
            pll_locked_flag[gi] <= 1'b1;
          end else if (slow_rise) begin
            lock_cnt[gi] <= lock_cnt[gi] - 6'h01;
          end
        end
      end

      always @(posedge clk) begin
        if (rst) begin
          pll_divider_out[gi*7 +: 7]    <= 7'h00;
          pll_multiplier_out[gi*8 +: 8] <= 8'h00;
        end else begin
          pll_divider_out[gi*7 +: 7]    <= pll_divider_field[gi];
          pll_multiplier_out[gi*8 +: 8] <= pll_multiplier_field[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enable and lock interrupt

  always @(posedge clk) begin
    if (rst) begin
      clock_irq_enable <= 2'h0;
      pll_lock_irq     <= 1'b0;
    end else begin
      if (wr_irq) begin
        clock_irq_enable <= reg_wdata[`SCPS_LOCK_B_BIT:`SCPS_LOCK_A_BIT];
      end
      pll_lock_irq <= |(pll_locked_flag & clock_irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always @* begin
    next_rdata = 32'h00000000;
    if (reg_addr == `SCPS_SUPPLY_MODE_REG) begin
      next_rdata[`SCPS_BYPASS_BIT] = xtal_bypass_enable;
    end else if (reg_addr == `SCPS_SUPPLY_STATUS_REG) begin
      next_rdata[`SCPS_SOURCE_BIT] = slow_xtal_select;
    end else if (reg_addr == `SCPS_CLOCK_STATUS_REG) begin
      next_rdata[`SCPS_SOURCE_BIT]     = slow_source_indicator;
      next_rdata[`SCPS_LOCK_A_BIT]     = pll_locked_flag[0];
      next_rdata[`SCPS_LOCK_B_BIT]     = pll_locked_flag[1];
      next_rdata[`SCPS_SLOW_VALID_BIT] = slow_clock_valid;
    end else if (reg_addr == `SCPS_CLOCK_IRQ_ENABLE_REG) begin
      next_rdata[`SCPS_LOCK_B_BIT:`SCPS_LOCK_A_BIT] = clock_irq_enable;
    end else if (reg_addr == `SCPS_MAIN_FREQ_MEASURE) begin
      next_rdata[15:0]                 = main_freq_count;
      next_rdata[`SCPS_FREQ_VALID_BIT] = main_freq_valid;
    end else if (reg_addr == `SCPS_PLL_CONFIG_REG_A) begin
      next_rdata[`SCPS_DIV_MSB:`SCPS_DIV_LSB]     = pll_divider_field[0];
      next_rdata[`SCPS_COUNT_MSB:`SCPS_COUNT_LSB] = pll_lock_delay_field[0];
      next_rdata[`SCPS_MUL_MSB:`SCPS_MUL_LSB]     = pll_multiplier_field[0];
    end else if (reg_addr == `SCPS_PLL_CONFIG_REG_B) begin
      next_rdata[`SCPS_DIV_MSB:`SCPS_DIV_LSB]     = pll_divider_field[1];
      next_rdata[`SCPS_COUNT_MSB:`SCPS_COUNT_LSB] = pll_lock_delay_field[1];
      next_rdata[`SCPS_MUL_MSB:`SCPS_MUL_LSB]     = pll_multiplier_field[1];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

/* hw/scps_defines.vh */
// Purpose: Constants for the slow clock and PLL setup block
// Assumes: 10 MHz system clock, byte addresses on an 8-bit register port
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef SCPS_DEFINES_VH
`define SCPS_DEFINES_VH

// Register offsets
`define SCPS_SUPPLY_CONTROL_REG   8'h00
`define SCPS_SUPPLY_MODE_REG      8'h04
`define SCPS_SUPPLY_STATUS_REG    8'h08
`define SCPS_CLOCK_STATUS_REG     8'h0c
`define SCPS_CLOCK_IRQ_ENABLE_REG 8'h10
`define SCPS_MAIN_FREQ_MEASURE    8'h14
`define SCPS_PLL_CONFIG_REG_A     8'h18
`define SCPS_PLL_CONFIG_REG_B     8'h1c

// Field positions
`define SCPS_XTAL_SELECT_BIT      0
`define SCPS_BYPASS_BIT           0
`define SCPS_SOURCE_BIT           0
`define SCPS_LOCK_A_BIT           1
`define SCPS_LOCK_B_BIT           2
`define SCPS_SLOW_VALID_BIT       3
`define SCPS_FREQ_VALID_BIT       16
`define SCPS_FREQ_RESTART_BIT     20
`define SCPS_DIV_LSB              0
`define SCPS_DIV_MSB              6
`define SCPS_COUNT_LSB            8
`define SCPS_COUNT_MSB            13
`define SCPS_MUL_LSB              16
`define SCPS_MUL_MSB              23

// Reset values
`define SCPS_DIV_RESET            7'h00
`define SCPS_MUL_RESET            8'h00
`define SCPS_COUNT_RESET          6'h00

// Timing
`define SCPS_CLK_HZ               10000000
`define SCPS_SLOW_VALID_US        100
// Slow valid delay in clk cycles, sized to the valid counter
`define SCPS_SLOW_VALID_CYCLES    11'h3e8
`define SCPS_MEASURE_SLOW_EDGES   5'h10
`define SCPS_XTAL_START_EDGES     4'h8

`endif

/* dv/scps_slow_clock_pll_asserts.sv */
// Purpose: Port assertions for the slow clock and PLL setup block
// Assumes: One clock domain; rst and backup_supply loss both reset the slow part
// Notes:   Bound to the top module below
`timescale 1ns/10ps
module scps_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        backup_supply,
  input wire logic        rc_osc_level,
  input wire logic        slow_xtal_input,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        slow_clock,
  input wire logic        slow_clock_valid,
  input wire logic        rc_osc_enable,
  input wire logic        xtal_osc_enable,
  input wire logic        xtal_bypass_enable,
  input wire logic        slow_source_indicator,
  input wire logic [1:0]  pll_enable,
  input wire logic [13:0] pll_divider_out,
  input wire logic [15:0] pll_multiplier_out,
  input wire logic [1:0]  pll_locked_flag,
  input wire logic        pll_lock_irq
);
  logic [10:0] up_cnt;
  logic        cfg_a_change;
  assign cfg_a_change = reg_write && reg_addr == 8'h18 &&
                        (reg_wdata[6:0] != pll_divider_out[6:0] ||
                         reg_wdata[23:16] != pll_multiplier_out[7:0]);
  // Cycles since the slow domain left reset
  always_ff @(posedge clk) begin
    if (rst || !backup_supply) begin
      up_cnt <= 11'h000;
    end else if (up_cnt != 11'h7ff) begin
      up_cnt <= up_cnt + 11'h001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !backup_supply);
  ////////////////////////////////////////////////////////////////////////////////
  chk_valid_early: assert property (up_cnt < 11'h384 |-> !slow_clock_valid)
    else $error("slow clock valid too early");
  chk_valid_late: assert property (up_cnt > 11'h44c |-> slow_clock_valid)
    else $error("slow clock valid too late");
  chk_rc_held: assert property (!slow_source_indicator |-> rc_osc_enable)
    else $error("rc oscillator off before switch");
  chk_rc_drop: assert property ($rose(slow_source_indicator) |-> ##1 !rc_osc_enable)
    else $error("rc oscillator not disabled after switch");
  chk_swap_low: assert property ($rose(slow_source_indicator) |->
    !$past(slow_clock) && !$past(rc_osc_level) && !$past(slow_xtal_input))
    else $error("source swapped while a clock was high");
  chk_src_sticky: assert property (slow_source_indicator |=> slow_source_indicator)
    else $error("crystal selection lost");
  chk_bypass_quiet: assert property (xtal_bypass_enable |-> !xtal_osc_enable)
    else $error("crystal oscillator on in bypass");
  chk_lock_enabled: assert property ((pll_locked_flag & ~pll_enable) == 2'h0)
    else $error("disabled pll shows lock");
  chk_lock_drop: assert property (cfg_a_change |=> !pll_locked_flag[0])
    else $error("lock kept after config change");
  chk_irq_source: assert property (pll_lock_irq |-> $past(|pll_locked_flag))
    else $error("lock irq without lock");
  chk_status_read: assert property (reg_read && reg_addr == 8'h0c |=>
    reg_rdata[3:0] == $past({slow_clock_valid, pll_locked_flag, slow_source_indicator}))
    else $error("clock status read wrong");
  cov_switch: cover property ($rose(slow_source_indicator));
  cov_lock: cover property ($rose(pll_locked_flag[0]));
  cov_irq: cover property ($rose(pll_lock_irq));
endmodule

bind scps_slow_clock_pll scps_checker scps_checker_inst (
  .clk, .rst, .backup_supply, .rc_osc_level, .slow_xtal_input, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .slow_clock, .slow_clock_valid, .rc_osc_enable,
  .xtal_osc_enable, .xtal_bypass_enable, .slow_source_indicator, .pll_enable,
  .pll_divider_out, .pll_multiplier_out, .pll_locked_flag, .pll_lock_irq
);

/* dv/tb.sv */
// Purpose: Register-level bench for the slow clock and PLL setup block
// Assumes: 10 MHz clock; RC slow period 16 clk, crystal 12 clk, main 2 clk
// Notes:   Frequency counts are checked within a small window
`timescale 1ns/10ps
module tb;
  logic        clk, rst, backup_supply, rc_osc_level, slow_xtal_input, main_clock_signal;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic        reg_write, reg_read, slow_clock, slow_clock_valid, rc_osc_enable;
  logic        xtal_osc_enable, xtal_bypass_enable, slow_source_indicator, pll_lock_irq;
  logic [1:0]  pll_enable, pll_locked_flag;
  logic [13:0] pll_divider_out;
  logic [15:0] pll_multiplier_out;
  integer      failures = 0;
  integer      total_checks = 0;
  integer      cycles = 0;
  integer      ph = 0;
  integer      i;

  scps_slow_clock_pll scps_slow_clock_pll_inst (
    .clk, .rst, .backup_supply, .rc_osc_level, .slow_xtal_input, .main_clock_signal,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .slow_clock,
    .slow_clock_valid, .rc_osc_enable, .xtal_osc_enable, .xtal_bypass_enable,
    .slow_source_indicator, .pll_enable, .pll_divider_out, .pll_multiplier_out,
    .pll_locked_flag, .pll_lock_irq
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator levels and hang guard
  always @(posedge clk) begin
    ph <= ph + 1;
    rc_osc_level <= (ph % 16) < 8;
    slow_xtal_input <= (ph % 12) < 6;
    main_clock_signal <= ph[0];
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic wait_clk(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic measure(input logic [15:0] lo, input logic [15:0] hi);
    integer k;
    wr(8'h14, 32'h0010_0000);
    rdr(8'h14);
    check("ready cleared", rd[16], 32'h0);
    for (k = 0; k < 300 && rd[16] !== 1'b1; k++) rdr(8'h14);
    rdr(8'h14);
    check("ready", rd[16], 32'h1);
    check("count", rd[15:0] >= lo && rd[15:0] <= hi, 32'h1);
    check("count nonzero", rd[15:0] != 16'h0, 32'h1);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    backup_supply = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wait_clk(1);
    check("rc enable", rc_osc_enable, 32'h1);
    check("xtal enable", xtal_osc_enable, 32'h0);
    rdr(8'h0c);
    check("clock status", rd, 32'h0);
    rdr(8'h18);
    check("pll a reset", rd, 32'h0);
    rdr(8'hfc);
    check("unmapped", rd, 32'h0);
    wait_clk(1000);
    check("slow valid", slow_clock_valid, 32'h1);
    rdr(8'h0c);
    check("status valid", rd, 32'h8);
    measure(16'h0078, 16'h0088);
    $display("test reset and measure done");
    wr(8'h10, 32'h2);
    wr(8'h18, 32'h0004_0302);
    wait_clk(4);
    check("div a", pll_divider_out[6:0], 32'h2);
    check("mul a", pll_multiplier_out[7:0], 32'h4);
    check("enable a", pll_enable[0], 32'h1);
    check("lock early", pll_locked_flag[0], 32'h0);
    wait_clk(80);
    check("lock a", pll_locked_flag[0], 32'h1);
    check("irq on", pll_lock_irq, 32'h1);
    rdr(8'h0c);
    check("status lock a", rd[1], 32'h1);
    rdr(8'h18);
    check("cfg a", rd, 32'h0004_0302);
    wr(8'h18, 32'h0004_0303);
    wait_clk(1);
    check("lock drop", pll_locked_flag[0], 32'h0);
    wait_clk(80);
    check("relock", pll_locked_flag[0], 32'h1);
    wr(8'h10, 32'h0);
    wait_clk(2);
    check("irq masked", pll_lock_irq, 32'h0);
    for (i = 0; i < 2; i++) begin
      wr(8'h1c, i == 0 ? 32'h0000_0005 : 32'h0005_0000);
      wait_clk(80);
      check("enable b", pll_enable[1], 32'h0);
      check("lock b", pll_locked_flag[1], 32'h0);
      check("div b", pll_divider_out[13:7], i == 0 ? 32'h5 : 32'h0);
      check("mul b", pll_multiplier_out[15:8], i == 0 ? 32'h0 : 32'h5);
    end
    $display("test pll done");
    wr(8'h04, 32'h1);
    wait_clk(1);
    check("bypass", xtal_bypass_enable, 32'h1);
    wr(8'h00, 32'h1);
    rdr(8'h08);
    check("supply status", rd, 32'h1);
    check("source early", slow_source_indicator, 32'h0);
    for (i = 0; i < 400 && slow_source_indicator !== 1'b1; i++) wait_clk(1);
    wait_clk(2);
    check("source", slow_source_indicator, 32'h1);
    check("rc off", rc_osc_enable, 32'h0);
    check("xtal osc bypassed", xtal_osc_enable, 32'h0);
    rdr(8'h0c);
    check("status source", rd[0], 32'h1);
    measure(16'h005a, 16'h0066);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wait_clk(20);
    check("sticky", slow_source_indicator, 32'h1);
    check("bypass kept", xtal_bypass_enable, 32'h1);
    @(posedge clk);
    backup_supply <= 1'b0;
    wait_clk(3);
    @(posedge clk);
    backup_supply <= 1'b1;
    wait_clk(2);
    check("source restored", slow_source_indicator, 32'h0);
    check("rc restored", rc_osc_enable, 32'h1);
    rdr(8'h08);
    check("select restored", rd, 32'h0);
    check("bypass cleared", xtal_bypass_enable, 32'h0);
    wr(8'h00, 32'h1);
    wait_clk(2);
    check("xtal osc on", xtal_osc_enable, 32'h1);
    check("rc kept on", rc_osc_enable, 32'h1);
    for (i = 0; i < 400 && slow_source_indicator !== 1'b1; i++) wait_clk(1);
    wait_clk(2);
    check("crystal source", slow_source_indicator, 32'h1);
    check("rc off crystal", rc_osc_enable, 32'h0);
    $display("test switch done");
    close_out;
  end
endmodule
